// file: inc/ctr_routing_defs.vh
// register indices, field positions, reset values and time-base figures
// for the counter/timer routing block; included by bare name
`ifndef CTR_ROUTING_DEFS_VH
`define CTR_ROUTING_DEFS_VH

// register indices; byte address is four times the index
`define IDX_IRQ_MASK    10'h206
`define IDX_IRQ_FLAG    10'h207
`define IDX_RELOAD0     10'h208
`define IDX_RELOAD1     10'h209
`define IDX_START0      10'h20C
`define IDX_START1      10'h20D
`define IDX_SETTING0    10'h20E
`define IDX_SETTING1    10'h20F

// flag and mask layout
`define BIT_FLAG0       2
`define BIT_FLAG1       3
// start control / output status layout
`define BIT_SOFT_GATE   0
`define BIT_OUT_STATUS  4
// setting register layout
`define BIT_CLK_SEL     0
`define BIT_GATE_SEL    1
`define BIT_OUT_ROUTE   2
`define BIT_IRQ_EN      3
`define BIT_RATE_LOW    4
`define BIT_RATE_HIGH   5
`define BIT_CASCADE     6

// reset values
`define RST_SETTING0    4'h0
`define RST_SETTING1    7'h00
`define RST_RELOAD      16'hFFFF
`define MIN_RELOAD      16'h0002

// time base
`define REF_CLK_HZ      250000000
`define RATE_100KHZ_HZ  100000
`define RATE_10KHZ_HZ   10000
`define RATE_1KHZ_HZ    1000
`define RATE_100HZ_HZ   100
`define DIV_100KHZ      (`REF_CLK_HZ / `RATE_100KHZ_HZ)
`define DIV_10KHZ       (`REF_CLK_HZ / `RATE_10KHZ_HZ)
`define DIV_1KHZ        (`REF_CLK_HZ / `RATE_1KHZ_HZ)
`define DIV_100HZ       (`REF_CLK_HZ / `RATE_100HZ_HZ)

`endif

// file: core/timebase_div.v
// synchronous divider producing a one-cycle enable at one of four rates
// assumes the rate select is a registered level
`timescale 1ns/100ps
module timebase_div
#(
  parameter integer DIV0 = 2500,
  parameter integer DIV1 = 25000,
  parameter integer DIV2 = 250000,
  parameter integer DIV3 = 2500000
)
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control and enable
  input  wire [1:0] rate_sel,
  output reg        tick
);

  reg  [21:0] cnt_q;
  reg  [1:0]  sel_q;
  reg  [21:0] limit;

  // full-width terminal values, cut to the counter width on purpose below
  wire [31:0] lim0 = DIV0 - 1;
  wire [31:0] lim1 = DIV1 - 1;
  wire [31:0] lim2 = DIV2 - 1;
  wire [31:0] lim3 = DIV3 - 1;

  always @*
  begin
    case (rate_sel)
      2'h0:    limit = lim0[21:0];
      2'h1:    limit = lim1[21:0];
      2'h2:    limit = lim2[21:0];
      2'h3:    limit = lim3[21:0];
      default: limit = lim0[21:0];
    endcase
  end

  // restart on a rate change so the first period is whole
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 22'h000000;
      sel_q <= 2'h0;
      tick  <= 1'b0;
    end
    else
    begin
      sel_q <= rate_sel;
      if (sel_q != rate_sel || cnt_q >= limit)
        cnt_q <= 22'h000000;
      else
        cnt_q <= cnt_q + 22'h000001;
      tick <= (sel_q == rate_sel) && (cnt_q == limit);
    end
  end

endmodule // timebase_div

// file: core/down_counter16.v
// gated down counter with reload, terminal pulse and output level
// assumes tick is a one-cycle enable and reload is held stable
`timescale 1ns/100ps
module down_counter16
#(
  parameter integer WIDTH = 16
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             tick,
  input  wire             gate,
  input  wire             load,
  input  wire [WIDTH-1:0] reload,
  // state
  output reg  [WIDTH-1:0] count,
  output reg              out,
  output reg              term
);

  localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
  localparam [WIDTH-1:0] TWO = {{(WIDTH-2){1'b0}}, 2'b10};

  // values below two would never produce a period, so they count as two
  wire [WIDTH-1:0] eff_reload = (reload < TWO) ? TWO : reload;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= {WIDTH{1'b1}};
      out   <= 1'b0;
      term  <= 1'b0;
    end
    else
    begin
      term <= 1'b0;
      if (load)
      begin
        count <= eff_reload;
        out   <= 1'b0;
      end
      else if (tick && gate)
      begin
        if (count <= ONE)
        begin
          count <= eff_reload;
          term  <= 1'b1;
          out   <= 1'b0;
        end
        else
        begin
          count <= count - ONE;
          out   <= (count == TWO);
        end
      end
    end
  end

endmodule // down_counter16

// file: core/counter_timer_routing.v
// counter/timer routing: two user down counters with clock, gate and
// output routing, interrupt flags and cascade, behind an APB slave
// assumes isolated inputs are already synchronous to REF_CLK
`timescale 1ns/100ps
`include "ctr_routing_defs.vh"

// Contract
// - counter one clock is the time base when its clock select is 0 and isolated input one when 1.
// - counter two clock is the time base when its clock select is 0 and isolated input three when 1.
// - the rate field picks 100 KHz, 10 KHz, 1 KHz or 100 Hz for codes 00, 01, 10, 11.
// - counter one gate is its software gate bit when gate select is 0 and isolated input zero when 1.
// - counter two gate is its software gate bit when gate select is 0 and isolated input two when 1.
// - a counter answers its clock only while its selected gate is high.
// - counter one output shows in its status bit, and also on isolated output two when routed.
// - counter two output shows in its status bit, and also on isolated output three when routed.
// - a flag reads 1 once its counter has raised an interrupt and 0 when none is pending.
// - writing 1 to a flag clears it and writing 0 leaves it alone.
// - while a flag stays set no further interrupt is presented for that counter.
// - each counter has an interrupt enable, off by default, that gates its interrupt.
// - the cascade bit joins the two counters into one 32-bit counter, off by default.
// - each counter is a 16-bit down counter with clock, gate and output counting 2 to 65535.
// - a write to the start register sets the soft gate and a read returns the output level.
module counter_timer_routing
#(
  parameter integer DIV_100KHZ = `DIV_100KHZ,
  parameter integer DIV_10KHZ  = `DIV_10KHZ,
  parameter integer DIV_1KHZ   = `DIV_1KHZ,
  parameter integer DIV_100HZ  = `DIV_100HZ
)
(
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // isolated inputs
  input  wire        ISOLATED_INPUT_ZERO,
  input  wire        ISOLATED_INPUT_ONE,
  input  wire        ISOLATED_INPUT_TWO,
  input  wire        ISOLATED_INPUT_THREE,
  // isolated outputs
  output reg         ISOLATED_OUTPUT_TWO,
  output reg         ISOLATED_OUTPUT_TWO_ROUTED,
  output reg         ISOLATED_OUTPUT_THREE,
  output reg         ISOLATED_OUTPUT_THREE_ROUTED,
  // interrupt
  output reg         IRQ
);

  // control registers
  reg  [3:0]  setting0_q;
  reg  [6:0]  setting1_q;
  reg         soft_gate0_q;
  reg         soft_gate1_q;
  reg  [1:0]  flag_q;
  reg  [15:0] reload0_q;
  reg  [15:0] reload1_q;
  reg         load0_q;
  reg         load1_q;
  reg         in_one_q;
  reg         in_three_q;

  wire [9:0]  idx = PADDR[11:2];
  wire        acc = PSEL & PENABLE;
  wire        wr  = acc & PWRITE & PREADY;

  wire        hit_mask  = (idx == `IDX_IRQ_MASK);
  wire        hit_flag  = (idx == `IDX_IRQ_FLAG);
  wire        hit_rl0   = (idx == `IDX_RELOAD0);
  wire        hit_rl1   = (idx == `IDX_RELOAD1);
  wire        hit_st0   = (idx == `IDX_START0);
  wire        hit_st1   = (idx == `IDX_START1);
  wire        hit_set0  = (idx == `IDX_SETTING0);
  wire        hit_set1  = (idx == `IDX_SETTING1);
  wire        mapped    = hit_mask | hit_flag | hit_rl0 | hit_rl1 |
                          hit_st0 | hit_st1 | hit_set0 | hit_set1;

  wire        cascade   = setting1_q[`BIT_CASCADE];
  wire [1:0]  rate_sel  = {setting1_q[`BIT_RATE_HIGH], setting1_q[`BIT_RATE_LOW]};

  wire        tb_tick;
  wire [15:0] count0;
  wire [15:0] count1;
  wire        out0;
  wire        out1;
  wire        term0;
  wire        term1;

  // time base
  timebase_div
  #(
    .DIV0 (DIV_100KHZ),
    .DIV1 (DIV_10KHZ),
    .DIV2 (DIV_1KHZ),
    .DIV3 (DIV_100HZ)
  )
  u_timebase
  (
    .clk      (REF_CLK),
    .rst      (RST),
    .rate_sel (rate_sel),
    .tick     (tb_tick)
  );

  // external clocks count on rising edges of the isolated inputs
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      in_one_q   <= 1'b0;
      in_three_q <= 1'b0;
    end
    else
    begin
      in_one_q   <= ISOLATED_INPUT_ONE;
      in_three_q <= ISOLATED_INPUT_THREE;
    end
  end

  wire ext_tick0 = ISOLATED_INPUT_ONE & ~in_one_q;
  wire ext_tick1 = ISOLATED_INPUT_THREE & ~in_three_q;

  wire tick0 = setting0_q[`BIT_CLK_SEL] ? ext_tick0 : tb_tick;
  wire src1  = setting1_q[`BIT_CLK_SEL] ? ext_tick1 : tb_tick;
  // the upper stage sees one clock per full period of the lower stage
  wire tick1 = cascade ? term0 : src1;

  wire gate0 = setting0_q[`BIT_GATE_SEL] ? ISOLATED_INPUT_ZERO : soft_gate0_q;
  wire gate1 = setting1_q[`BIT_GATE_SEL] ? ISOLATED_INPUT_TWO : soft_gate1_q;

  down_counter16
  #(
    .WIDTH (16)
  )
  u_counter0
  (
    .clk    (REF_CLK),
    .rst    (RST),
    .tick   (tick0),
    .gate   (gate0),
    .load   (load0_q),
    .reload (reload0_q),
    .count  (count0),
    .out    (out0),
    .term   (term0)
  );

  down_counter16
  #(
    .WIDTH (16)
  )
  u_counter1
  (
    .clk    (REF_CLK),
    .rst    (RST),
    .tick   (tick1),
    .gate   (gate1),
    .load   (load1_q),
    .reload (reload1_q),
    .count  (count1),
    .out    (out1),
    .term   (term1)
  );

  // register writes
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      setting0_q   <= `RST_SETTING0;
      setting1_q   <= `RST_SETTING1;
      soft_gate0_q <= 1'b0;
      soft_gate1_q <= 1'b0;
      reload0_q    <= `RST_RELOAD;
      reload1_q    <= `RST_RELOAD;
      load0_q      <= 1'b0;
      load1_q      <= 1'b0;
    end
    else
    begin
      load0_q <= wr & hit_rl0;
      load1_q <= wr & hit_rl1;
      if (wr && hit_set0)
        setting0_q <= PWDATA[3:0];
      if (wr && hit_set1)
        setting1_q <= PWDATA[6:0];
      // the mask is a second view of the two enable bits
      if (wr && hit_mask)
      begin
        setting0_q[`BIT_IRQ_EN] <= PWDATA[`BIT_FLAG0];
        setting1_q[`BIT_IRQ_EN] <= PWDATA[`BIT_FLAG1];
      end
      if (wr && hit_st0)
        soft_gate0_q <= PWDATA[`BIT_SOFT_GATE];
      if (wr && hit_st1)
        soft_gate1_q <= PWDATA[`BIT_SOFT_GATE];
      if (wr && hit_rl0)
        reload0_q <= PWDATA[15:0];
      if (wr && hit_rl1)
        reload1_q <= PWDATA[15:0];
    end
  end

  // sticky flags; a terminal pulse in the clearing cycle keeps the flag set
  wire [1:0] term_ev = {term1, term0};
  wire [1:0] clr     = (wr && hit_flag) ?
                       {PWDATA[`BIT_FLAG1], PWDATA[`BIT_FLAG0]} : 2'h0;

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      flag_q <= 2'h0;
    else
      flag_q <= term_ev | (flag_q & ~clr);
  end

  // read data
  reg [31:0] rdata;

  always @*
  begin
    rdata = 32'h00000000;
    case (1'b1)
      hit_mask:
      begin
        rdata[`BIT_FLAG0] = setting0_q[`BIT_IRQ_EN];
        rdata[`BIT_FLAG1] = setting1_q[`BIT_IRQ_EN];
      end
      hit_flag:
      begin
        rdata[`BIT_FLAG0] = flag_q[0];
        rdata[`BIT_FLAG1] = flag_q[1];
      end
      hit_rl0:  rdata[15:0] = count0;
      hit_rl1:  rdata[15:0] = count1;
      hit_st0:  rdata[`BIT_OUT_STATUS] = out0;
      hit_st1:  rdata[`BIT_OUT_STATUS] = out1;
      hit_set0: rdata[3:0] = setting0_q;
      hit_set1: rdata[6:0] = setting1_q;
      default:  rdata = 32'h00000000;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end
    else
    begin
      PREADY  <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & ~mapped;
      if (acc && !PREADY && !PWRITE)
        PRDATA <= rdata;
    end
  end

  // outputs
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ISOLATED_OUTPUT_TWO          <= 1'b0;
      ISOLATED_OUTPUT_TWO_ROUTED   <= 1'b0;
      ISOLATED_OUTPUT_THREE        <= 1'b0;
      ISOLATED_OUTPUT_THREE_ROUTED <= 1'b0;
      IRQ                          <= 1'b0;
    end
    else
    begin
      ISOLATED_OUTPUT_TWO_ROUTED   <= setting0_q[`BIT_OUT_ROUTE];
      ISOLATED_OUTPUT_TWO          <= setting0_q[`BIT_OUT_ROUTE] & out0;
      ISOLATED_OUTPUT_THREE_ROUTED <= setting1_q[`BIT_OUT_ROUTE];
      ISOLATED_OUTPUT_THREE        <= setting1_q[`BIT_OUT_ROUTE] & out1;
      // a flag already set absorbs new events, so no second interrupt shows
      IRQ <= |(flag_q & {setting1_q[`BIT_IRQ_EN], setting0_q[`BIT_IRQ_EN]});
    end
  end

endmodule // counter_timer_routing

// file: verification/ctr_routing_monitor.sv
// port checker for the counter routing block
// assumes one clock domain and the apb slave timing of the block
`timescale 1ns/100ps
module ctr_routing_monitor
(
  // clock and reset
  input wire        REF_CLK,
  input wire        RST,
  // apb
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // isolated outputs and interrupt
  input wire        ISOLATED_OUTPUT_TWO,
  input wire        ISOLATED_OUTPUT_TWO_ROUTED,
  input wire        ISOLATED_OUTPUT_THREE,
  input wire        ISOLATED_OUTPUT_THREE_ROUTED,
  input wire        IRQ
);
  wire acc = PSEL && PENABLE && PREADY && PWRITE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_rdy_ans;
    PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY;
  endproperty
  a_rdy_ans: assert property (p_rdy_ans) else $error("ready timing wrong");
  property p_err_rd;
    PSLVERR && !PWRITE |-> PREADY && PRDATA == 32'h0;
  endproperty
  a_err_rd: assert property (p_err_rd) else $error("refused read not zero");
  property p_route2;
    !ISOLATED_OUTPUT_TWO_ROUTED |-> !ISOLATED_OUTPUT_TWO;
  endproperty
  a_route2: assert property (p_route2) else $error("output two leaks");
  property p_route3;
    !ISOLATED_OUTPUT_THREE_ROUTED |-> !ISOLATED_OUTPUT_THREE;
  endproperty
  a_route3: assert property (p_route3) else $error("output three leaks");
  property p_rsel2;
    acc && PADDR == 12'h838 |-> ##2 ISOLATED_OUTPUT_TWO_ROUTED == $past(PWDATA[2], 2);
  endproperty
  a_rsel2: assert property (p_rsel2) else $error("route two not taken");
  property p_rsel3;
    acc && PADDR == 12'h83C |-> ##2 ISOLATED_OUTPUT_THREE_ROUTED == $past(PWDATA[2], 2);
  endproperty
  a_rsel3: assert property (p_rsel3) else $error("route three not taken");
  property p_mask_off;
    acc && PADDR == 12'h818 && PWDATA[3:2] == 2'h0 |-> ##2 !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq high");
  // the fastest time base tick is ten cycles in this bench
  property p_out_width;
    $rose(ISOLATED_OUTPUT_TWO) |-> ISOLATED_OUTPUT_TWO [*8];
  endproperty
  a_out_width: assert property (p_out_width) else $error("output pulse short");
  c_err: cover property (PSLVERR);
  c_irq: cover property (IRQ);
  c_out: cover property ($rose(ISOLATED_OUTPUT_TWO));
endmodule // ctr_routing_monitor

// file: verification/iso_channel_model.sv
// isolated channel model: gate levels and clock pulses on the inputs
// assumes go is a one-cycle request taken only while idle
`timescale 1ns/100ps
module iso_channel_model
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // requests
  input  wire [1:0] gate_lv,
  input  wire [1:0] go,
  input  wire       slow,
  // isolated lines and status
  output wire       in0,
  output wire       in1,
  output wire       in2,
  output wire       in3,
  output wire       busy
);
  reg  [2:0] cnt_q;
  reg        ch_q;
  // a slow pulse stays high five cycles, a prompt one two
  wire       hi = cnt_q > 3'h2;
  assign busy = cnt_q != 3'h0;
  assign in0 = gate_lv[0];
  assign in2 = gate_lv[1];
  assign in1 = hi && !ch_q;
  assign in3 = hi && ch_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 3'h0;
      ch_q  <= 1'b0;
    end
    else if (!busy && go != 2'h0)
    begin
      cnt_q <= slow ? 3'h7 : 3'h4;
      ch_q  <= go[1];
    end
    else if (busy)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule // iso_channel_model

// file: verification/counter_timer_routing_tb.sv
// self-checking bench for the counter routing block over apb
// assumes the isolated channel model on the isolated inputs
`timescale 1ns/100ps
module counter_timer_routing_tb;
  reg         REF_CLK, RST, PSEL, PENABLE, PWRITE, slow, err;
  reg  [11:0] PADDR, c;
  reg  [31:0] PWDATA, r;
  reg  [1:0]  gate_lv, go;
  wire [31:0] PRDATA;
  wire        PREADY, PSLVERR, IRQ, in0, in1, in2, in3, o2, o2r, o3, o3r, busy;
  integer     error_cnt, cmp_count, n, k, w;
  counter_timer_routing #(.DIV_100KHZ(10), .DIV_10KHZ(20), .DIV_1KHZ(30), .DIV_100HZ(40)) u_dut
  (
    .REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .ISOLATED_INPUT_ZERO(in0), .ISOLATED_INPUT_ONE(in1), .ISOLATED_INPUT_TWO(in2),
    .ISOLATED_INPUT_THREE(in3), .ISOLATED_OUTPUT_TWO(o2), .ISOLATED_OUTPUT_TWO_ROUTED(o2r),
    .ISOLATED_OUTPUT_THREE(o3), .ISOLATED_OUTPUT_THREE_ROUTED(o3r), .IRQ
  );
  iso_channel_model u_iso
  (
    .clk(REF_CLK), .rst(RST), .gate_lv(gate_lv), .go(go), .slow(slow),
    .in0(in0), .in1(in1), .in2(in2), .in3(in3), .busy(busy)
  );
  task report_and_stop;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task tmo;
  begin
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  endtask
  task apb(input w_en, input [11:0] a, input [31:0] d);
  begin
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w_en;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
    begin
      n = n + 1;
      if (n > 20)
        tmo;
      @(posedge REF_CLK);
    end
    r = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 32'h0);
    chk(r, e);
  end
  endtask
  task pulse(input [11:0] ch);
  begin
    @(posedge REF_CLK);
    go[ch] <= 1'b1;
    @(posedge REF_CLK);
    go[ch] <= 1'b0;
    n = 0;
    @(posedge REF_CLK);
    while (busy === 1'b1)
    begin
      n = n + 1;
      if (n > 20)
        tmo;
      @(posedge REF_CLK);
    end
  end
  endtask
  task wout(input v);
  begin
    n = 0;
    while (o2 !== v)
    begin
      n = n + 1;
      if (n > 500)
        tmo;
      @(posedge REF_CLK);
    end
  end
  endtask
  initial
  begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    {RST, PSEL, PENABLE, PWRITE, slow, PADDR, PWDATA, gate_lv, go} = {1'b1, 52'h0};
    error_cnt = 0;
    cmp_count = 0;
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    // registers at indices 206..209 and 20C..20F
    for (k = 0; k < 8; k = k + 1)
      rd(k < 4 ? 12'h818 + k * 4 : 12'h820 + k * 4, k == 2 || k == 3 ? 32'hFFFF : 32'h0);
    apb(1'b0, 12'h800, 32'h0);
    chk({r[30:0], err}, 32'h1);
    $display("test reset and unmapped done");
    apb(1'b1, 12'h820, 32'h3);
    apb(1'b1, 12'h830, 32'h1);
    k = 0;
    while (r[2] !== 1'b1)
    begin
      k = k + 1;
      if (k > 100)
        tmo;
      apb(1'b0, 12'h81C, 32'h0);
    end
    apb(1'b1, 12'h830, 32'h0);
    chk(IRQ, 32'h0);
    apb(1'b1, 12'h818, 32'h4);
    repeat (2) @(posedge REF_CLK);
    chk(IRQ, 32'h1);
    apb(1'b1, 12'h81C, 32'h0);
    rd(12'h81C, 32'h4);
    apb(1'b1, 12'h81C, 32'h4);
    rd(12'h81C, 32'h0);
    chk(IRQ, 32'h0);
    apb(1'b1, 12'h820, 32'h7);
    repeat (100) @(posedge REF_CLK);
    rd(12'h820, 32'h7);
    $display("test flag and gate done");
    for (c = 12'h0; c < 12'h2; c = c + 12'h1)
    begin
      slow <= c[0];
      apb(1'b1, 12'h838 + (c << 2), 32'h3);
      apb(1'b1, 12'h820 + (c << 2), 32'h5);
      gate_lv[c] <= 1'b1;
      pulse(c);
      rd(12'h820 + (c << 2), 32'h4);
      gate_lv[c] <= 1'b0;
      pulse(c);
      rd(12'h820 + (c << 2), 32'h4);
      apb(1'b1, 12'h838 + (c << 2), 32'h0);
    end
    $display("test isolated clock and gate done");
    apb(1'b1, 12'h838, 32'h4);
    apb(1'b1, 12'h820, 32'h2);
    for (k = 0; k < 4; k = k + 1)
    begin
      apb(1'b1, 12'h83C, k << 4);
      apb(1'b1, 12'h830, 32'h1);
      wout(1'b0);
      wout(1'b1);
      w = 0;
      while (o2 === 1'b1 && w < 100)
      begin
        @(posedge REF_CLK);
        w = w + 1;
      end
      chk(w, 10 * (k + 1));
      apb(1'b1, 12'h830, 32'h0);
    end
    $display("test time base rates done");
    apb(1'b1, 12'h838, 32'h3);
    apb(1'b1, 12'h834, 32'h1);
    apb(1'b1, 12'h83C, 32'h44);
    apb(1'b1, 12'h820, 32'h2);
    apb(1'b1, 12'h824, 32'h5);
    gate_lv <= 2'h1;
    slow <= 1'b0;
    pulse(12'h0);
    pulse(12'h0);
    rd(12'h824, 32'h4);
    // reload the upper stage to two so one more lower period drives its last period
    apb(1'b1, 12'h824, 32'h2);
    pulse(12'h0);
    pulse(12'h0);
    chk({o3r, o3}, 32'h3);
    rd(12'h834, 32'h10);
    apb(1'b1, 12'h818, 32'h4);
    repeat (2) @(posedge REF_CLK);
    chk(IRQ, 32'h1);
    apb(1'b1, 12'h818, 32'h0);
    repeat (3) @(posedge REF_CLK);
    chk(IRQ, 32'h0);
    $display("test cascade done");
    report_and_stop;
  end
endmodule // counter_timer_routing_tb
bind counter_timer_routing ctr_routing_monitor u_mon
(
  .REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .ISOLATED_OUTPUT_TWO, .ISOLATED_OUTPUT_TWO_ROUTED, .ISOLATED_OUTPUT_THREE,
  .ISOLATED_OUTPUT_THREE_ROUTED, .IRQ
);
